/* design/byte_lane_serializer.sv */
// Serializer that sends the valid bytes of one word, lowest lane first, to the transmitter
`timescale 1ns/1ps
module byte_lane_serializer (
  input  wire logic   pclk,     // Clock
  input  wire logic   presetn,  // Asynchronous reset, active low
  word_lane_if.dst    wl,       // Word from the unpacker
  output logic [7:0]  tx_data,  // Byte to the transmitter
  output logic        tx_valid, // Byte valid
  output logic        tx_last,  // Last byte of packet
  input  wire logic   tx_ready  // Transmitter takes the byte
);
  typedef struct packed {
    logic [31:0] word;  // Shifting word, current byte in the low lane
    logic [2:0]  cnt;   // Bytes still to send
    logic        last;  // Word closes the packet
  } ser_t;

  localparam ser_t SER_RESET = '{default: '0};

  ser_t s_reg;   // Registered state
  ser_t s_next;  // Next state

  // One word at a time keeps the packet attributes stable for the word in flight
  assign wl.ready = (s_reg.cnt == 3'h0);
  assign tx_data  = s_reg.word[7:0];
  assign tx_valid = (s_reg.cnt != 3'h0);
  assign tx_last  = s_reg.last && (s_reg.cnt == 3'h1);

  // Load on an accepted word, shift on every byte taken
  always_comb begin
    s_next = s_reg;
    if (wl.valid && wl.ready) begin
      s_next.word = wl.data >> {wl.first_lane, 3'h0};  // RULE_13
      s_next.cnt  = wl.nbytes;                          // RULE_15
      s_next.last = wl.last;
    end else if (tx_valid && tx_ready) begin
      s_next.word = {8'h00, s_reg.word[31:8]};
      s_next.cnt  = s_reg.cnt - 3'h1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= SER_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

/* design/tx_buffer_command_unpacker.sv */
// Transmit buffer command unpacker: parses command words, strips offsets and filler, checks lengths
//
// Summary of operation
// RULE_01 - Opening-fragment bit starts a new packet
// RULE_02 - Closing-fragment bit completes the packet
// RULE_03 - Command A low bits: buffer byte count
// RULE_04 - Count plus alignment gives filler words
// RULE_05 - Summed buffer sizes mismatch raises error
// RULE_06 - Packet tag copied into status word
// RULE_07 - Host picks tags; hardware ignores uniqueness
// RULE_08 - CRC-disable bit drops automatic CRC
// RULE_09 - Pad-disable bit stops short frame padding
// RULE_10 - Pad disabled always keeps the CRC
// RULE_11 - Command B low bits: packet length
// RULE_12 - Data starts after the command words
// RULE_13 - Offset low bits choose first byte lane
// RULE_14 - Offset upper bits skip whole words
// RULE_15 - Unused trailing bytes never forwarded
// RULE_16 - Host pads buffer to end alignment
// RULE_17 - Device discards end alignment filler
// RULE_18 - Host writes zero to reserved bits
// RULE_19 - Alignment codes: 4, 16, 32, reserved
// RULE_20 - Done request raises buffer-loaded flag
// RULE_21 - Command B only on opening fragments
// RULE_22 - Fragments in order; sum restarts
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module tx_buffer_command_unpacker
  import txbuf_pkg::*;
#(
  parameter int ADDR_W = 8  // APB address width
) (
  input  wire logic              pclk,          // Clock, 20 MHz
  input  wire logic              presetn,       // Asynchronous reset, active low
  input  wire logic [ADDR_W-1:0] paddr,         // APB address
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB access phase
  input  wire logic              pwrite,        // APB direction
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic [31:0]            prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error for unmapped address
  input  wire logic [31:0]       fifo_data,     // Host buffer word
  input  wire logic              fifo_valid,    // Host word present
  output logic                   fifo_ready,    // Word consumed
  output logic [7:0]             tx_data,       // Byte to transmitter
  output logic                   tx_valid,      // Byte valid
  output logic                   tx_last,       // Last byte of packet
  input  wire logic              tx_ready,      // Transmitter takes byte
  output logic                   tx_crc_append, // Append CRC to current packet
  output logic                   tx_pad_short,  // Pad current packet if short
  output logic                   status_valid,  // Status word pulse
  output logic [31:0]            status_word    // Tag and error of finished packet
);
  import txbuf_pkg::*;

  // Only paddr[7:0] is decoded, so a narrower bus could not reach the register map
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  typedef enum logic [1:0] {CMD_A, CMD_B, BODY, FINISH} state_t;

  typedef struct packed {
    state_t            state;     // Parser state
    logic              enable;    // Control enable
    logic              err_flag;  // transmit_error_flag
    logic              done_flag; // buffer_loaded_flag
    logic              in_pkt;    // A packet is open
    logic              pkt_err;   // Error seen in current packet
    logic              ls;        // Current buffer closes the packet
    logic              irq_req;   // Current buffer asks for done flag
    logic [LEN_W-1:0]  sum;       // Running byte sum
    logic [LEN_W-1:0]  plen;      // Declared packet length
    logic [LEN_W-1:0]  rem;       // Bytes left in buffer
    logic [15:0]       tag;       // Packet tag
    logic              crc_dis;   // CRC suppress
    logic              pad_dis;   // Pad suppress
    logic [CNT_W-1:0]  widx;      // Word index in buffer body
    logic [CNT_W-1:0]  skip;      // Whole offset words
    logic [CNT_W-1:0]  dend;      // Index after last data word
    logic [CNT_W-1:0]  tw;        // Total body words
    logic [1:0]        lane;      // First byte lane
    logic [15:0]       last_tag;  // Tag of last finished packet
    logic [15:0]       pkt_count; // Finished packets
    logic              st_valid;  // Status pulse
    logic [31:0]       st_word;   // Status word
    logic [31:0]       rdata;     // APB read data
    logic              slverr;    // APB error
  } st_t;

  localparam st_t ST_RESET = '{state: CMD_A, enable: CTRL_EN_RST, default: '0};

  st_t r_reg;   // Registered state
  st_t r_next;  // Next state

  word_lane_if wl ();

  // Body word, command A, APB and event decode
  logic             body_skip;  // Offset word
  logic             body_data;  // Data word
  logic [2:0]       room;       // Bytes available in this word
  logic [2:0]       take;       // Bytes forwarded from this word
  logic [1:0]       cur_lane;   // Lane of first byte in this word
  logic             take_word;  // Word consumed this cycle
  logic             a_fs;       // Opening fragment bit of command A
  logic [1:0]       a_lane;     // Lane field of command A
  logic [2:0]       a_skip;     // Whole-word offset of command A
  logic [LEN_W-1:0] a_size;     // Buffer byte count of command A
  logic [LEN_W:0]   span;       // Lane plus size plus rounding
  logic [CNT_W-1:0] a_dw;       // Data words of the buffer
  logic [CNT_W-1:0] a_used;     // Offset plus data words
  logic [CNT_W-1:0] a_mask;     // Alignment mask in words
  logic [CNT_W-1:0] a_tw;       // Body words after rounding
  logic             apb_setup;  // APB setup cycle
  logic             apb_wr;     // APB write takes effect
  logic             err_set;    // Error event this cycle
  logic             done_set;   // Done event this cycle

  assign a_fs   = fifo_data[A_FS_BIT];
  assign a_lane = fifo_data[A_OFF_LANE_HI:A_OFF_LO];                       // RULE_13
  assign a_skip = fifo_data[A_OFF_HI:A_OFF_WLO];                           // RULE_14
  assign a_size = fifo_data[SIZE_HI:0];                                    // RULE_03
  assign span   = {1'b0, a_size} + {{(LEN_W-1){1'b0}}, a_lane} + 12'h003;
  assign a_dw   = span[LEN_W:2];
  assign a_used = a_dw + {{(CNT_W-3){1'b0}}, a_skip};

  // Filler words: body rounded up to the alignment, reserved code treated as 4-byte
  always_comb begin
    unique case (fifo_data[A_ALIGN_HI:A_ALIGN_LO])                          // RULE_19
      ALIGN_16: a_mask = 10'h003;
      ALIGN_32: a_mask = 10'h007;
      default:  a_mask = 10'h000;
    endcase
  end
  assign a_tw = (a_used + a_mask) & ~a_mask;                                // RULE_04

  assign body_skip = (r_reg.widx < r_reg.skip);                             // RULE_14
  assign body_data = !body_skip && (r_reg.widx < r_reg.dend);
  assign cur_lane  = (r_reg.widx == r_reg.skip) ? r_reg.lane : 2'h0;        // RULE_13
  assign room      = 3'h4 - {1'b0, cur_lane};
  assign take      = (r_reg.rem < {8'h00, room}) ? r_reg.rem[2:0] : room;   // RULE_15

  // Word offer to the serializer; empty data words are dropped silently
  assign wl.valid      = (r_reg.state == BODY) && body_data && (take != 3'h0) && fifo_valid;
  assign wl.data       = fifo_data;
  assign wl.first_lane = cur_lane;
  assign wl.nbytes     = take;
  assign wl.last       = r_reg.ls && (r_reg.rem == {8'h00, take});          // RULE_02

  // Input handshake; command B waits for the serializer so attributes never change under a word
  always_comb begin
    fifo_ready = 1'b0;
    if (r_reg.enable) begin
      unique case (r_reg.state)
        CMD_A:  fifo_ready = 1'b1;
        CMD_B:  fifo_ready = wl.ready;
        BODY:   fifo_ready = (body_data && (take != 3'h0)) ? wl.ready : 1'b1; // RULE_17
        FINISH: fifo_ready = 1'b0;
      endcase
    end
  end
  assign take_word = fifo_valid && fifo_ready;

  assign tx_crc_append = !r_reg.crc_dis || r_reg.pad_dis;                   // RULE_08 RULE_10
  assign tx_pad_short  = !r_reg.pad_dis;                                    // RULE_09
  assign status_valid  = r_reg.st_valid;
  assign status_word   = r_reg.st_word;
  assign pready        = 1'b1;
  assign prdata        = r_reg.rdata;
  assign pslverr       = r_reg.slverr;
  assign apb_setup     = psel && !penable;
  assign apb_wr        = psel && penable && pwrite && !r_reg.slverr;

  // Parser, sticky flags and register file
  always_comb begin
    r_next          = r_reg;
    r_next.st_valid = 1'b0;
    err_set         = 1'b0;
    done_set        = 1'b0;
    unique case (r_reg.state)
      CMD_A: begin
        if (take_word) begin
          r_next.ls      = fifo_data[A_LS_BIT];
          r_next.irq_req = fifo_data[A_IRQ_BIT];
          r_next.lane    = a_lane;
          r_next.skip    = {{(CNT_W-3){1'b0}}, a_skip};
          r_next.dend    = a_used;
          r_next.tw      = a_tw;
          r_next.rem     = a_size;
          r_next.widx    = '0;
          if (a_fs) begin
            r_next.sum     = a_size;                                        // RULE_01 RULE_22
            r_next.in_pkt  = 1'b1;
            r_next.pkt_err = (fifo_data[A_ALIGN_HI:A_ALIGN_LO] == ALIGN_RSV);
            r_next.state   = CMD_B;                                         // RULE_21
          end else begin
            r_next.sum     = r_reg.sum + a_size;                            // RULE_05
            r_next.pkt_err = r_reg.pkt_err || !r_reg.in_pkt ||
                             (fifo_data[A_ALIGN_HI:A_ALIGN_LO] == ALIGN_RSV);
            r_next.state   = (a_tw == '0) ? FINISH : BODY;                  // RULE_12
          end
        end
      end
      CMD_B: begin
        if (take_word) begin
          r_next.tag     = fifo_data[B_TAG_HI:B_TAG_LO];                    // RULE_06
          r_next.crc_dis = fifo_data[B_CRC_DIS_BIT];                        // RULE_08
          r_next.pad_dis = fifo_data[B_PAD_DIS_BIT];                        // RULE_09
          r_next.plen    = fifo_data[SIZE_HI:0];                            // RULE_11
          r_next.state   = (r_reg.tw == '0) ? FINISH : BODY;                // RULE_12
        end
      end
      BODY: begin
        if (take_word) begin
          if (body_data) begin
            r_next.rem = r_reg.rem - {8'h00, take};
          end
          r_next.widx = r_reg.widx + 10'h001;
          if (r_reg.widx == r_reg.tw - 10'h001) begin
            r_next.state = FINISH;                                          // RULE_17
          end
        end
      end
      FINISH: begin
        done_set     = r_reg.irq_req;                                       // RULE_20
        r_next.state = CMD_A;
        if (r_reg.ls) begin
          err_set          = r_reg.pkt_err || (r_reg.sum != r_reg.plen);    // RULE_05 RULE_11
          r_next.in_pkt    = 1'b0;
          r_next.st_valid  = 1'b1;
          r_next.st_word   = {r_reg.tag, err_set, 15'h0000};                // RULE_06
          r_next.last_tag  = r_reg.tag;
          r_next.pkt_count = r_reg.pkt_count + 16'h0001;
        end
      end
    endcase
    // Register access; a hardware set in the same cycle wins over a write-one clear
    r_next.err_flag  = r_reg.err_flag  || err_set;
    r_next.done_flag = r_reg.done_flag || done_set;
    if (apb_wr) begin
      if (paddr[7:0] == CONTROL_OFS) begin
        r_next.enable = pwdata[CTRL_EN_BIT];
      end else if (paddr[7:0] == STATUS_OFS) begin
        r_next.err_flag  = (r_reg.err_flag  && !pwdata[STAT_ERR_BIT])  || err_set;
        r_next.done_flag = (r_reg.done_flag && !pwdata[STAT_DONE_BIT]) || done_set;
      end
    end
    // Read data and error are prepared in the setup cycle and shown during access
    if (apb_setup) begin
      r_next.rdata  = '0;
      r_next.slverr = 1'b0;
      unique case (paddr[7:0])
        CONTROL_OFS:   r_next.rdata[CTRL_EN_BIT] = r_reg.enable;
        STATUS_OFS:    r_next.rdata[STAT_BUSY_BIT:STAT_ERR_BIT] =
                         {r_reg.state != CMD_A, r_reg.done_flag, r_reg.err_flag};
        LAST_TAG_OFS:  r_next.rdata[15:0] = r_reg.last_tag;
        PKT_COUNT_OFS: r_next.rdata[15:0] = r_reg.pkt_count;
        default:       r_next.slverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  byte_lane_serializer u_ser (
    .pclk     (pclk),
    .presetn  (presetn),
    .wl       (wl.dst),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_last  (tx_last),
    .tx_ready (tx_ready)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_a_taken;
    r_reg.state == CMD_A && take_word;
  endsequence
  sequence cmd_b_taken;
    r_reg.state == CMD_B && take_word;
  endsequence

  fs_opens_b_a: assert property (cmd_a_taken ##0 a_fs |=> r_reg.state == CMD_B && r_reg.in_pkt) // RULE_01
    else $error("opening fragment did not expect command B");
  nofs_skip_b_a: assert property (cmd_a_taken ##0 !a_fs |=> r_reg.state != CMD_B) // RULE_21
    else $error("command B expected without opening fragment");
  sum_restart_a: assert property (cmd_a_taken ##0 a_fs |=> r_reg.sum == $past(fifo_data[SIZE_HI:0])) // RULE_22
    else $error("byte sum not restarted at opening fragment");
  len_check_a: assert property (r_reg.state == FINISH && r_reg.ls && r_reg.sum != r_reg.plen
                                |=> r_reg.err_flag && status_word[ST_ERR_BIT]) // RULE_05
    else $error("length mismatch not flagged");
  pad_off_crc_a: assert property (cmd_b_taken ##0 fifo_data[B_PAD_DIS_BIT] |=> tx_crc_append && !tx_pad_short) // RULE_10
    else $error("pad suppress lost the CRC");
  crc_off_a: assert property (cmd_b_taken ##0 fifo_data[B_CRC_DIS_BIT] && !fifo_data[B_PAD_DIS_BIT]
                              |=> !tx_crc_append && tx_pad_short) // RULE_08
    else $error("CRC suppress ignored");
  tag_status_a: assert property (r_reg.state == FINISH && r_reg.ls |=> status_valid
                                 && status_word[B_TAG_HI:B_TAG_LO] == $past(r_reg.tag)) // RULE_06
    else $error("status tag wrong");
  done_flag_a: assert property (r_reg.state == FINISH && r_reg.irq_req |=> r_reg.done_flag) // RULE_20
    else $error("buffer loaded flag not raised");
  filler_drop_a: assert property (r_reg.state == BODY && !body_skip && !body_data && fifo_valid && r_reg.enable
                                  |-> fifo_ready && !wl.valid) // RULE_17
    else $error("filler word not discarded");
  skip_drop_a: assert property (r_reg.state == BODY && body_skip |-> !wl.valid) // RULE_14
    else $error("offset word forwarded");
  lane_bound_a: assert property (wl.valid |-> {1'b0, wl.nbytes} + {2'h0, wl.first_lane} <= 4'h4
                                 && {8'h00, wl.nbytes} <= r_reg.rem) // RULE_15
    else $error("bytes beyond word or buffer forwarded");
endmodule

/* design/txbuf_pkg.sv */
// Package with command word layout, register map and shared constants of the transmit buffer unpacker
package txbuf_pkg;
  // Command word A fields
  localparam int A_IRQ_BIT      = 31;       // Buffer-done request bit
  localparam int A_ALIGN_HI     = 25;       // End alignment field, high bit
  localparam int A_ALIGN_LO     = 24;       // End alignment field, low bit
  localparam int A_OFF_HI       = 20;       // Start offset field, high bit
  localparam int A_OFF_WLO      = 18;       // Start offset, low bit of the whole-word part
  localparam int A_OFF_LANE_HI  = 17;       // Start offset, high bit of the byte-lane part
  localparam int A_OFF_LO       = 16;       // Start offset field, low bit
  localparam int A_FS_BIT       = 13;       // Opening fragment bit
  localparam int A_LS_BIT       = 12;       // Closing fragment bit
  localparam int SIZE_HI        = 10;       // Byte count field, high bit (both words)
  // Command word B fields
  localparam int B_TAG_HI       = 31;       // Packet tag, high bit
  localparam int B_TAG_LO       = 16;       // Packet tag, low bit
  localparam int B_CRC_DIS_BIT  = 13;       // Suppress automatic CRC
  localparam int B_PAD_DIS_BIT  = 12;       // Suppress short frame padding
  // End alignment codes
  localparam logic [1:0] ALIGN_4  = 2'h0;   // 4-byte end alignment
  localparam logic [1:0] ALIGN_16 = 2'h1;   // 16-byte end alignment
  localparam logic [1:0] ALIGN_32 = 2'h2;   // 32-byte end alignment
  localparam logic [1:0] ALIGN_RSV = 2'h3;  // Reserved code
  // Status word layout
  localparam int ST_ERR_BIT     = 15;       // Packet error bit in the status word
  // Register byte offsets
  localparam logic [7:0] CONTROL_OFS   = 8'h00; // Enable
  localparam logic [7:0] STATUS_OFS    = 8'h04; // Sticky flags and busy
  localparam logic [7:0] LAST_TAG_OFS  = 8'h08; // Tag of last finished packet
  localparam logic [7:0] PKT_COUNT_OFS = 8'h0c; // Finished packet count
  // Register field positions
  localparam int CTRL_EN_BIT    = 0;        // Unpacker enable
  localparam int STAT_ERR_BIT   = 0;        // transmit_error_flag, write one to clear
  localparam int STAT_DONE_BIT  = 1;        // buffer_loaded_flag, write one to clear
  localparam int STAT_BUSY_BIT  = 2;        // Unpacker inside a buffer
  // Reset values
  localparam logic CTRL_EN_RST  = 1'b0;     // Unpacker disabled after reset
  // Counter widths
  localparam int CNT_W          = 10;       // Word index inside one buffer
  localparam int LEN_W          = 11;       // Byte counts
endpackage

/* design/word_lane_if.sv */
// Interface carrying one data word with its valid byte lanes to the serializer
`timescale 1ns/1ps
interface word_lane_if;
  logic        valid;       // Word offered
  logic        ready;       // Serializer idle
  logic [31:0] data;        // Raw data word
  logic [1:0]  first_lane;  // Lane of first valid byte
  logic [2:0]  nbytes;      // Valid bytes, 1 to 4
  logic        last;        // Word ends the packet
  modport src (output valid, data, first_lane, nbytes, last, input ready);
  modport dst (input valid, data, first_lane, nbytes, last, output ready);
endinterface

/* testbench/host_fifo_model.sv */
// Host model that writes buffer words into the data FIFO port in order
`timescale 1ns/1ps
module host_fifo_model (
  input  wire logic        pclk,       // Clock
  input  wire logic        presetn,    // Asynchronous reset, active low
  input  wire logic        fifo_ready, // Word consumed
  output logic [31:0]      fifo_data,  // Buffer word
  output logic             fifo_valid  // Word present
);
  logic [31:0] word_q[$]; // Words waiting to be written
  // Queue a word; the host never reorders what it writes
  task automatic push(input logic [31:0] w);
    word_q.push_back(w);
  endtask
  // Offer words one at a time and hold each until consumed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_valid <= 1'b0;
      fifo_data  <= 32'h0;
    end else if (!fifo_valid || fifo_ready) begin
      if (word_q.size() > 0) begin
        fifo_data  <= word_q.pop_front();
        fifo_valid <= 1'b1;
      end else begin
        // Idle bus shows a changing pattern so a stale word cannot pass
        fifo_valid <= 1'b0;
        fifo_data  <= ~fifo_data;
      end
    end
  end
endmodule

/* testbench/tb_tx_buffer_command_unpacker.sv */
// Self-checking testbench for the transmit buffer command unpacker
`timescale 1ns/1ps
module tb_tx_buffer_command_unpacker;
  import txbuf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, tx_ready; // Clock, reset, APB controls, MAC ready
  logic [7:0]  paddr;         // APB address
  logic [31:0] pwdata;        // APB write data
  logic [31:0] prdata, fifo_data, status_word, st_seen, rd;
  logic        pready, pslverr, fifo_valid, fifo_ready, tx_valid, tx_last, status_valid, err;
  logic [7:0]  tx_data;       // Byte to the transmitter
  logic        tx_crc_append, tx_pad_short, crc_seen, pad_seen;
  logic [8:0]  rx_q[$];       // Received bytes with last flag on top
  int          n_mismatch = 0, comparisons = 0, cycles = 0, st_cnt = 0;
  tx_buffer_command_unpacker u_tx_buffer_command_unpacker (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_data(fifo_data), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_crc_append(tx_crc_append), .tx_pad_short(tx_pad_short), .status_valid(status_valid),
    .status_word(status_word));
  host_fifo_model u_host_fifo_model (.pclk(pclk), .presetn(presetn), .fifo_ready(fifo_ready),
    .fifo_data(fifo_data), .fifo_valid(fifo_valid));
  // 20 MHz clock
  always #25 pclk = ~pclk;
  // Transmitter stalls every other cycle to exercise backpressure
  always @(posedge pclk) tx_ready <= ~tx_ready;
  // Collect bytes, packet controls and status pulses; also cut a hang short
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      rx_q.push_back({tx_last, tx_data});
      crc_seen = tx_crc_append;
      pad_seen = tx_pad_short;
    end
    if (status_valid) begin
      st_seen = status_word;
      st_cnt++;
    end
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Wait for status and all bytes, then compare them
  task automatic expect_pkt(input logic [8:0] exp[$], input logic [31:0] st);
    for (int i = 0; i < 400 && (st_cnt == 0 || rx_q.size() < exp.size()); i++) @(posedge pclk);
    check("byte count", rx_q.size(), exp.size());
    foreach (exp[i]) if (rx_q.size() > 0) check("byte", rx_q.pop_front(), exp[i]);
    check("status word", st_seen, st);
    st_cnt = 0;
  endtask
  task automatic regs_after_reset();
    apb(1'b0, CONTROL_OFS, 32'h0, rd, err); check("control reset", rd, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err); check("status reset", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0, rd, err); check("unmapped error", err, 32'h1);
    apb(1'b1, CONTROL_OFS, 32'h1, rd, err); apb(1'b0, CONTROL_OFS, 32'h0, rd, err);
    check("control enable", rd, 32'h1);
  endtask
  // Lane 1 start, one skipped word, 16-byte end alignment, CRC suppressed
  task automatic single_buffer();
    u_host_fifo_model.push(32'h0105_3005);
    u_host_fifo_model.push(32'h1234_2005);
    u_host_fifo_model.push(32'hdead_beef);
    u_host_fifo_model.push(32'h0302_01ee);
    u_host_fifo_model.push(32'hcccc_0504);
    u_host_fifo_model.push(32'hf111_f111);
    expect_pkt({9'h001, 9'h002, 9'h003, 9'h004, 9'h105}, 32'h1234_0000);
    check("crc append", crc_seen, 32'h0);
    check("pad short", pad_seen, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err); check("no flags", rd, 32'h0);
  endtask
  // Two fragments whose sizes do not add up to the declared length
  task automatic fragmented_error();
    u_host_fifo_model.push(32'h8000_2004);
    u_host_fifo_model.push(32'habcd_3007);
    u_host_fifo_model.push(32'h1413_1211);
    u_host_fifo_model.push(32'h0000_1002);
    u_host_fifo_model.push(32'h7777_1615);
    expect_pkt({9'h011, 9'h012, 9'h013, 9'h014, 9'h015, 9'h116}, 32'habcd_8000);
    check("crc kept", crc_seen, 32'h1);
    check("pad off", pad_seen, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err); check("flags set", rd, 32'h3);
    apb(1'b1, STATUS_OFS, 32'h3, rd, err);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err); check("flags cleared", rd, 32'h0);
    apb(1'b0, PKT_COUNT_OFS, 32'h0, rd, err); check("packet count", rd, 32'h2);
    apb(1'b0, LAST_TAG_OFS, 32'h0, rd, err); check("last tag", rd, 32'habcd);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    pclk     = 1'b0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    tx_ready = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    regs_after_reset();
    single_buffer();
    fragmented_error();
    conclude();
  end
endmodule
